/* File: verilog/nvpc_ctrl.sv */
// Purpose: program/erase control registers and sequencer for the nonvolatile array
// Assumes: byte register port driven by the host bridge on this clock, one access per cycle
// Notes: array side is a simple one-cycle start with busy timing kept here
// Behaviour
// - erase scope bit: 0 whole chip, 1 one selected page
// - 3-bit erase page selector, reset zero, names page 0..7
// - program scope bit: 0 whole chip, 1 one selected page
// - 3-bit program page selector, reset zero, names page 0..7
// - program/erase allowed only with customer key in key register
// - pages 0 and 1 reserved; customer key cannot select them in page scope, but whole-chip ops still go
// - key register 8-bit read-write, clears to zero at reset
// - host loads data then sets program trigger; device programs it
// - host picks erase target then sets erase trigger; device erases
// - nonvolatile-backed registers refuse writes until unlock bit is one
`timescale 1ns/100ps
`include "nvpc_cfg.svh"
module nvpc_ctrl
	import nvpc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic nvm_reg_write_unlock,
	output logic nvm_array_start,
	output logic nvm_array_erase,
	output logic nvm_array_page_scope,
	output logic [2:0] nvm_array_page,
	output logic nvm_busy
);
	logic [7:0] page_cfg_r;
	logic [7:0] page_cfg_nxt;
	logic [7:0] key_r;
	logic [7:0] key_nxt;
	logic unlock_r;
	logic unlock_nxt;
	logic prog_allowed;
	logic erase_allowed;
	logic prog_req;
	logic erase_req;
	nvpc_state_t state_r;
	nvpc_state_t state_nxt;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic start_r;
	logic start_nxt;
	logic erase_r;
	logic erase_nxt;
	logic scope_r;
	logic scope_nxt;
	logic [2:0] page_r;
	logic [2:0] page_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;

	// scope and page fields of the config byte
	logic erase_scope_select;
	logic [2:0] erase_page_select;
	logic program_scope_select;
	logic [2:0] program_page_select;
	assign erase_scope_select = page_cfg_r[`NVPC_BIT_ERASE_SCOPE];
	assign erase_page_select = page_cfg_r[`NVPC_ERASE_PAGE_HI:`NVPC_ERASE_PAGE_LO];
	assign program_scope_select = page_cfg_r[`NVPC_BIT_PROG_SCOPE];
	assign program_page_select = page_cfg_r[`NVPC_PROG_PAGE_HI:`NVPC_PROG_PAGE_LO];

	// same check for both kinds of request, each on its own page field
	nvpc_gate u_gate_prog
	(
		.key(key_r),
		.page_scope(program_scope_select),
		.page(program_page_select),
		.allowed(prog_allowed)
	);
	nvpc_gate u_gate_erase
	(
		.key(key_r),
		.page_scope(erase_scope_select),
		.page(erase_page_select),
		.allowed(erase_allowed)
	);

	// triggers are self-clearing: they are seen only in the write cycle
	always_comb
	begin
		prog_req = reg_wr && (reg_addr == `NVPC_ADDR_CTRL0) && reg_wdata[`NVPC_BIT_PROG_TRIG];
		erase_req = reg_wr && (reg_addr == `NVPC_ADDR_CTRL0) && reg_wdata[`NVPC_BIT_ERASE_TRIG];
	end

	// register writes; config byte is array-backed so it waits for unlock
	always_comb
	begin
		page_cfg_nxt = page_cfg_r;
		key_nxt = key_r;
		unlock_nxt = unlock_r;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`NVPC_ADDR_CTRL0:
				begin
					unlock_nxt = reg_wdata[`NVPC_BIT_UNLOCK];
				end
				`NVPC_ADDR_PAGE_CFG:
				begin
					// changing the target mid-operation would corrupt it, so hold while busy
					if (unlock_r && (state_r == NVPC_IDLE))
					begin
						page_cfg_nxt = reg_wdata;
					end
				end
				`NVPC_ADDR_KEY:
				begin
					key_nxt = reg_wdata;
				end
				default:
				begin
					page_cfg_nxt = page_cfg_r;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			page_cfg_r <= `NVPC_PAGE_CFG_RESET;
			key_r <= `NVPC_KEY_RESET;
			unlock_r <= 1'b0;
		end
		else
		begin
			page_cfg_r <= page_cfg_nxt;
			key_r <= key_nxt;
			unlock_r <= unlock_nxt;
		end
	end

	// sequencer: accepted request starts the array and holds busy for the op time
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		start_nxt = 1'b0;
		erase_nxt = erase_r;
		scope_nxt = scope_r;
		page_nxt = page_r;
		unique case (state_r)
			NVPC_IDLE:
			begin
				// an allowed program wins if both triggers land together; refused ones just vanish
				if (prog_req && prog_allowed)
				begin
					state_nxt = NVPC_PROGRAM;
					start_nxt = 1'b1;
					erase_nxt = 1'b0;
					scope_nxt = program_scope_select;
					page_nxt = program_page_select;
					cnt_nxt = `NVPC_OP_CYCLES;
				end
				else if (erase_req && erase_allowed)
				begin
					state_nxt = NVPC_ERASE;
					start_nxt = 1'b1;
					erase_nxt = 1'b1;
					scope_nxt = erase_scope_select;
					page_nxt = erase_page_select;
					cnt_nxt = `NVPC_OP_CYCLES;
				end
			end
			NVPC_PROGRAM, NVPC_ERASE:
			begin
				cnt_nxt = cnt_r - 16'h0001;
				if (cnt_r == 16'h0001)
				begin
					state_nxt = NVPC_IDLE;
				end
			end
			default:
			begin
				state_nxt = NVPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state_r <= NVPC_IDLE;
			cnt_r <= 16'h0000;
			start_r <= 1'b0;
			erase_r <= 1'b0;
			scope_r <= 1'b0;
			page_r <= 3'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			start_r <= start_nxt;
			erase_r <= erase_nxt;
			scope_r <= scope_nxt;
			page_r <= page_nxt;
		end
	end

	// registered read data; triggers read back as zero, busy shows in bit 3
	always_comb
	begin
		unique case (reg_addr)
			`NVPC_ADDR_CTRL0:
			begin
				rdata_nxt = 8'h00;
				rdata_nxt[`NVPC_BIT_UNLOCK] = unlock_r;
				rdata_nxt[`NVPC_BIT_BUSY] = (state_r != NVPC_IDLE);
			end
			`NVPC_ADDR_PAGE_CFG:
			begin
				rdata_nxt = page_cfg_r;
			end
			`NVPC_ADDR_KEY:
			begin
				rdata_nxt = key_r;
			end
			default:
			begin
				rdata_nxt = 8'h00;
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rdata_r <= 8'h00;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign nvm_reg_write_unlock = unlock_r;
	assign nvm_array_start = start_r;
	assign nvm_array_erase = erase_r;
	assign nvm_array_page_scope = scope_r;
	assign nvm_array_page = page_r;
	assign nvm_busy = (state_r != NVPC_IDLE);
endmodule

/* File: verilog/nvpc_cfg.svh */
// Purpose: named constants for the nonvolatile page program/erase control block
// Assumes: byte-wide register port with 8-bit addresses
// Notes: definitions only
`ifndef NVPC_CFG_SVH
`define NVPC_CFG_SVH

`define NVPC_ADDR_CTRL0 8'h98
`define NVPC_ADDR_PAGE_CFG 8'h99
`define NVPC_ADDR_KEY 8'h9A
`define NVPC_CUSTOMER_KEY 8'hB7
`define NVPC_KEY_RESET 8'h00
`define NVPC_PAGE_CFG_RESET 8'h00
`define NVPC_FIRST_OPEN_PAGE 3'h2
`define NVPC_BIT_ERASE_SCOPE 7
`define NVPC_BIT_PROG_SCOPE 3
`define NVPC_BIT_UNLOCK 4
`define NVPC_BIT_PROG_TRIG 2
`define NVPC_BIT_ERASE_TRIG 1
`define NVPC_BIT_BUSY 3
`define NVPC_ERASE_PAGE_HI 6
`define NVPC_ERASE_PAGE_LO 4
`define NVPC_PROG_PAGE_HI 2
`define NVPC_PROG_PAGE_LO 0
`define NVPC_OP_CYCLES 16'h0010

`endif

/* File: verilog/nvpc_pkg.sv */
// Purpose: types shared by the nonvolatile page program/erase control block
// Assumes: nothing beyond the cfg header
// Notes: state encoding only
package nvpc_pkg;
	typedef enum logic [1:0]
	{
		NVPC_IDLE = 2'h0,
		NVPC_PROGRAM = 2'h1,
		NVPC_ERASE = 2'h2
	} nvpc_state_t;
endpackage

/* File: verilog/nvpc_gate.sv */
// Purpose: decides whether a program or erase request may proceed
// Assumes: key and page come from registers on the same clock
// Notes: purely combinational
`timescale 1ns/100ps
`include "nvpc_cfg.svh"
module nvpc_gate
	import nvpc_pkg::*;
(
	input wire logic [7:0] key,
	input wire logic page_scope,
	input wire logic [2:0] page,
	output logic allowed
);
	// customer key required; reserved pages 0 and 1 closed to it in page scope only
	always_comb
	begin
		allowed = (key == `NVPC_CUSTOMER_KEY);
		if (page_scope && (page < `NVPC_FIRST_OPEN_PAGE))
		begin
			allowed = 1'b0;
		end
	end
endmodule

/* File: tb/nvpc_ctrl_props.sv */
// Purpose: port checker for nvpc_ctrl
// Assumes: one clock, async reset
// Notes: bound below
`timescale 1ns/100ps
module nvpc_chk
(
	input wire logic clock,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic nvm_reg_write_unlock,
	input wire logic nvm_array_start,
	input wire logic nvm_array_erase,
	input wire logic nvm_array_page_scope,
	input wire logic [2:0] nvm_array_page,
	input wire logic nvm_busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// a control write carrying a trigger is the only cause of a start
	wire ctl = reg_wr && reg_addr == 8'h98;
	wire trg = ctl && reg_wdata[2:1] != 2'h0;
	start_once_a: assert property (nvm_array_start |=> !nvm_array_start) else $error("start len");
	start_busy_a: assert property (nvm_array_start |-> nvm_busy) else $error("start idle");
	busy_span_a: assert property ($rose(nvm_busy) |-> nvm_busy[*8] ##1 nvm_busy[*8] ##1 !nvm_busy)
		else $error("busy span");
	unlock_bit_a: assert property (ctl |=> nvm_reg_write_unlock == $past(reg_wdata[4]))
		else $error("unlock");
	start_cause_a: assert property (nvm_array_start |-> $past(trg)) else $error("cause");
	// a refused program lets an erase in the same write through, so match kind to its own bit
	op_kind_a: assert property (nvm_array_start |-> (nvm_array_erase ? $past(reg_wdata[1]) : $past(reg_wdata[2])))
		else $error("kind");
	page_open_a: assert property (nvm_array_start && nvm_array_page_scope |-> nvm_array_page > 3'h1)
		else $error("page");
	busy_block_a: assert property (nvm_array_start |-> !$past(nvm_busy)) else $error("busy");
endmodule
bind nvpc_ctrl nvpc_chk nvpc_chk_i
(
	.clock(clock),
	.rst(rst),
	.reg_wr(reg_wr),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.nvm_reg_write_unlock(nvm_reg_write_unlock),
	.nvm_array_start(nvm_array_start),
	.nvm_array_erase(nvm_array_erase),
	.nvm_array_page_scope(nvm_array_page_scope),
	.nvm_array_page(nvm_array_page),
	.nvm_busy(nvm_busy)
);

/* File: tb/nvpc_host.sv */
// Purpose: host model on the register port
// Assumes: tasks called one at a time
// Notes: signals change only at rising edges
`timescale 1ns/100ps
module nvpc_host
(
	input wire logic clock,
	output logic reg_wr = 1'b0,
	output logic [7:0] reg_addr = 8'h00,
	output logic [7:0] reg_wdata = 8'h00,
	output logic rd_v = 1'b0
);
	// write: strobe stands one edge, then stale data is scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// read: data is registered, so it is flagged one edge later
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		@(posedge clock);
		rd_v <= 1'b1;
		@(posedge clock);
		rd_v <= 1'b0;
	endtask
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for nvpc_ctrl
// Assumes: nvpc_host drives the register port
// Notes: driver queues notes, watcher compares
`timescale 1ns/100ps
module tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic wr, rv, st, er, sc;
	logic [7:0] ad, wd, rdat, rnd = 8'h30;
	logic [2:0] pg;
	logic [7:0] rq[$];
	logic [4:0] sq[$];
	int bad_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #5 clock = ~clock;
	nvpc_host nvpc_host_i (.clock(clock), .reg_wr(wr), .reg_addr(ad), .reg_wdata(wd), .rd_v(rv));
	nvpc_ctrl nvpc_ctrl_i (.clock(clock), .rst(rst), .reg_wr(wr), .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat),
		.nvm_reg_write_unlock(), .nvm_array_start(st), .nvm_array_erase(er), .nvm_array_page_scope(sc),
		.nvm_array_page(pg), .nvm_busy());
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic cmp_rd(input logic [7:0] exp);
		n_tests++;
		if (rdat !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t read %h", $time, rdat);
		end
	endtask
	task automatic cmp_op(input logic [4:0] exp);
		n_tests++;
		if ({er, sc, pg} !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %0t start %h", $time, {er, sc, pg});
		end
	endtask
	task automatic end_of_test();
		bad_count += sq.size() + rq.size();
		$display("counts: %0d bad, %0d tests", bad_count, n_tests);
		if (bad_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// outputs are settled by the falling edge; an empty queue means an unexpected result
	always @(negedge clock)
	begin
		if (st !== 1'b0)
			cmp_op(sq.size() ? sq.pop_front() : 'x);
		if (rv)
			cmp_rd(rq.size() ? rq.pop_front() : 'x);
	end
	// hang guard, several times the expected run
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count++;
			end_of_test();
		end
	end
	// configure, read back, trigger, note a start only if it must come
	task automatic op(input logic [7:0] c, input logic [7:0] t, input logic ok);
		nvpc_host_i.wr(8'h99, c);
		rq.push_back(c);
		nvpc_host_i.rd(8'h99);
		nvpc_host_i.wr(8'h98, t);
		if (ok)
			sq.push_back(t[2] ? {1'b0, c[3:0]} : {1'b1, c[7:4]});
		// busy must show in ctrl0 only for an accepted trigger; unlock stays set
		rq.push_back(ok ? 8'h18 : 8'h10);
		nvpc_host_i.rd(8'h98);
		repeat (20) @(posedge clock);
	endtask
	// main sequence
	initial
	begin
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		rq = '{8'h00, 8'h00, 8'h00, 8'h00};
		nvpc_host_i.rd(8'h9A);
		nvpc_host_i.rd(8'h99);
		nvpc_host_i.wr(8'h99, 8'hFF);
		nvpc_host_i.rd(8'h99);
		rnd = lfsr(rnd);
		nvpc_host_i.wr(8'h9A, rnd | 8'h40);
		nvpc_host_i.wr(8'h9B, rnd);
		nvpc_host_i.rd(8'h9B);
		nvpc_host_i.wr(8'h98, 8'h10);
		op(8'h80, 8'h12, 1'b0);
		nvpc_host_i.wr(8'h9A, 8'hB7);
		op(8'h00, 8'h16, 1'b1);
		op(8'h00, 8'h12, 1'b1);
		for (int i = 0; i < 16; i++)
		begin
			rnd = lfsr(rnd);
			op({1'b1, i[2:0], 1'b1, i[2:0]} ^ (rnd & (i[3] ? 8'h07 : 8'h70)), i[3] ? 8'h12 : 8'h14,
				i[2:1] != 2'h0);
		end
		end_of_test();
	end
endmodule
